// file: pkg/scs_params.svh
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// ----------------------------------------
// field codes
// ----------------------------------------
`define SCS_CLK_EXT       3'h7
`define SCS_MODE_PORT     2'h0
`define SCS_MODE_SIO      2'h1
`define SCS_MODE_I2C      2'h2
`define SCS_XFER_TX       2'h0
`define SCS_XFER_TXRX     2'h2
`define SCS_XFER_RX       2'h3
`define SCS_BITS          4'h8
`define SCS_DIV_W         12

// ----------------------------------------
// divider half periods per clock-select code
// ----------------------------------------
`define SCS_DIV0          12'h004
`define SCS_DIV1          12'h008
`define SCS_DIV2          12'h010
`define SCS_DIV3          12'h020
`define SCS_DIV4          12'h040
`define SCS_DIV5          12'h080
`define SCS_DIV6          12'h100

`endif

// file: pkg/scs_pkg.sv
package scs_pkg;

	typedef enum logic [2:0] {
		SCS_IDLE  = 3'b001,
		SCS_SHIFT = 3'b010,
		SCS_WAIT  = 3'b100
	} scs_state_t;

endpackage

// file: logic/scs_clkdiv.sv
`timescale 1ns/100ps
`include "scs_params.svh"

module scs_clkdiv
	import scs_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// control
	input  wire logic       run,
	input  wire logic [2:0] clk_sel,
	// output
	output logic            tick
);

	typedef struct packed {
		logic [`SCS_DIV_W-1:0] cnt;
		logic                  tick;
	} scs_div_t;

	scs_div_t s_q;
	scs_div_t s_d;
	logic [`SCS_DIV_W-1:0] half;

	// ----------------------------------------
	// half period lookup
	// ----------------------------------------
	always_comb begin
		unique case (clk_sel)
			3'h0: half = `SCS_DIV0;
			3'h1: half = `SCS_DIV1;
			3'h2: half = `SCS_DIV2;
			3'h3: half = `SCS_DIV3;
			3'h4: half = `SCS_DIV4;
			3'h5: half = `SCS_DIV5;
			3'h6: half = `SCS_DIV6;
			default: half = `SCS_DIV6;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= half - 12'h001) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 12'h001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule

// file: logic/scs_shifter.sv
`timescale 1ns/100ps
`include "scs_params.svh"

module scs_shifter
	import scs_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// control fields
	input  wire logic [1:0] interface_mode,
	input  wire logic [1:0] transfer_mode_field,
	input  wire logic [2:0] clk_sel,
	input  wire logic [2:0] bit_count_field,
	input  wire logic       transfer_start_bit,
	input  wire logic       transfer_inhibit_bit,
	// shared data buffer access
	input  wire logic       buf_wr,
	input  wire logic [7:0] buf_wdata,
	input  wire logic       buf_rd,
	output logic      [7:0] shared_data_buffer,
	// status and event
	output logic            transfer_active_flag,
	output logic            shift_active_flag,
	output logic            buffer_service_irq,
	// serial pins
	input  wire logic       serial_clock_pin_in,
	output logic            serial_clock_pin_out,
	output logic            serial_clock_pin_oe_n,
	output logic            serial_out_pin,
	output logic            serial_out_pin_oe_n,
	input  wire logic       serial_in_pin
);

	typedef struct packed {
		scs_state_t  st;
		logic [1:0]  sck_sync;
		logic [1:0]  sin_sync;
		logic        sck_prev;
		logic        sck_int;
		logic [7:0]  sh;
		logic [3:0]  cnt;
		logic [7:0]  dbuf;
		logic        full;
		logic        irq;
		logic        sof;
		logic        stop_req;
		logic        drop;
	} scs_state_reg_t;

	scs_state_reg_t s_q;
	scs_state_reg_t s_d;

	logic ext_clk;
	logic sio_on;
	logic is_tx;
	logic is_rx;
	logic tick;
	logic sck_now;
	logic fall;
	logic rise;
	logic svc_pending;
	logic div_run;

	assign ext_clk = (clk_sel == `SCS_CLK_EXT);
	assign sio_on  = (interface_mode == `SCS_MODE_SIO);
	assign is_tx   = (transfer_mode_field == `SCS_XFER_TX) || (transfer_mode_field == `SCS_XFER_TXRX);
	assign is_rx   = (transfer_mode_field != `SCS_XFER_TX);

	// ----------------------------------------
	// buffer service wait
	// ----------------------------------------
	// transmit waits for a write, receive for a read, duplex for a write alone, since a write also clears irq
	always_comb begin
		if (!is_rx) begin
			svc_pending = !s_q.full;
		end else if (is_tx) begin
			svc_pending = !s_q.full || s_q.irq;
		end else begin
			svc_pending = s_q.full;
		end
	end

	assign div_run = sio_on && !ext_clk && (s_q.st == SCS_SHIFT) &&
		!(svc_pending && s_q.cnt == 4'h0 && s_q.sck_int);

	scs_clkdiv u_div (
		.core_clk (core_clk),
		.nrst     (nrst),
		.run      (div_run),
		.clk_sel  (clk_sel),
		.tick     (tick)
	);

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// synchroniser first stage is read only by its second stage
	assign sck_now = ext_clk ? s_q.sck_sync[1] : s_q.sck_int;
	assign fall    = s_q.sck_prev && !sck_now;
	assign rise    = !s_q.sck_prev && sck_now;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sck_sync = {s_q.sck_sync[0], serial_clock_pin_in};
		s_d.sin_sync = {s_q.sin_sync[0], serial_in_pin};
		s_d.sck_prev = sck_now;
		s_d.irq = s_q.irq;

		// software access to the shared buffer
		if (buf_rd) begin
			s_d.irq = 1'b0;
			if (is_rx) begin
				s_d.full = 1'b0;
			end
		end
		if (buf_wr) begin
			s_d.dbuf = buf_wdata;
			s_d.full = 1'b1;
			s_d.irq  = 1'b0;
		end

		if (tick) begin
			s_d.sck_int = !s_q.sck_int;
		end

		if (!transfer_start_bit) begin
			s_d.stop_req = (s_q.st != SCS_IDLE);
		end

		unique case (s_q.st)
			SCS_IDLE: begin
				s_d.sck_int = 1'b1;
				s_d.cnt = 4'h0;
				if (sio_on && transfer_start_bit && !transfer_inhibit_bit) begin
					s_d.st = SCS_SHIFT;
					s_d.stop_req = 1'b0;
					s_d.drop = 1'b0;
				end
			end
			SCS_SHIFT, SCS_WAIT: begin
				if (s_q.cnt == 4'h0 && !transfer_start_bit) begin
					// nothing left to shift once start is withdrawn at a byte boundary
					s_d.st = SCS_IDLE;
				end else if (fall) begin
					if (s_q.cnt == 4'h0) begin
						if (is_tx) begin
							// load a new byte, or the stale buffer contents again when the buffer ran dry
							s_d.sh   = s_q.dbuf;
							s_d.sof  = s_q.dbuf[0];
							// a write in the same cycle refills the buffer
							s_d.full = buf_wr;
							if (!is_rx) begin
								s_d.irq = 1'b1;
							end
						end
						s_d.cnt  = 4'h1;
						s_d.drop = is_rx && ext_clk && (is_tx ? s_q.irq : s_q.full);
					end else if (is_tx) begin
						// shift register moves on rise, so bit 0 is the next bit out
						s_d.sof = s_q.sh[0];
					end
				end else if (rise && s_q.cnt != 4'h0) begin
					s_d.sh = {is_rx && s_q.sin_sync[1], s_q.sh[7:1]};
					if (s_q.cnt == `SCS_BITS) begin
						s_d.cnt = 4'h0;
						if (is_rx && !s_q.drop) begin
							s_d.dbuf = {s_q.sin_sync[1], s_q.sh[7:1]};
							s_d.full = 1'b1;
							s_d.irq  = 1'b1;
						end
						if (s_q.stop_req || !transfer_start_bit) begin
							s_d.st = SCS_IDLE;
						end
					end else begin
						s_d.cnt = s_q.cnt + 4'h1;
					end
				end
				if (transfer_inhibit_bit || !sio_on) begin
					// partial byte is simply discarded
					s_d.st = SCS_IDLE;
					s_d.cnt = 4'h0;
				end
			end
			default: begin
				s_d.st = SCS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{st: SCS_IDLE, sck_sync: 2'h3, sck_prev: 1'b1, sck_int: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign shared_data_buffer    = s_q.dbuf;
	assign transfer_active_flag  = (s_q.st != SCS_IDLE);
	assign shift_active_flag     = (s_q.cnt != 4'h0);
	assign buffer_service_irq    = s_q.irq;
	assign serial_clock_pin_out  = s_q.sck_int;
	assign serial_clock_pin_oe_n = !(sio_on && !ext_clk);
	assign serial_out_pin        = s_q.sof;
	assign serial_out_pin_oe_n   = !sio_on;

endmodule

// file: bench/scs_properties.sv
`timescale 1ns/100ps
module scs_properties (
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic [1:0] interface_mode,
	input wire logic [1:0] transfer_mode_field,
	input wire logic [2:0] clk_sel,
	input wire logic [2:0] bit_count_field,
	input wire logic       transfer_start_bit,
	input wire logic       transfer_inhibit_bit,
	input wire logic       buf_wr,
	input wire logic [7:0] buf_wdata,
	input wire logic       buf_rd,
	input wire logic [7:0] shared_data_buffer,
	input wire logic       transfer_active_flag,
	input wire logic       shift_active_flag,
	input wire logic       buffer_service_irq,
	input wire logic       serial_clock_pin_in,
	input wire logic       serial_clock_pin_out,
	input wire logic       serial_clock_pin_oe_n,
	input wire logic       serial_out_pin,
	input wire logic       serial_out_pin_oe_n,
	input wire logic       serial_in_pin
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence int_fall;
		!serial_clock_pin_oe_n && clk_sel == 3'h0 && $fell(serial_clock_pin_out);
	endsequence
	chk_half_period: assert property (disable iff (!nrst || transfer_inhibit_bit)
		int_fall |=> !serial_clock_pin_out [*3])
		else $error("serial clock low phase too short");
	chk_out_on_fall: assert property (
		$changed(serial_out_pin) && !serial_clock_pin_oe_n && !transfer_inhibit_bit |-> !serial_clock_pin_out)
		else $error("serial out changed outside low clock");
	chk_clk_idle: assert property (
		!serial_clock_pin_oe_n && !transfer_active_flag [*2] |-> serial_clock_pin_out)
		else $error("serial clock moved while idle");
	chk_ext_src: assert property ((clk_sel == 3'h7) [*2] |-> serial_clock_pin_oe_n)
		else $error("serial clock driven in external mode");
	chk_port_idle: assert property (
		(interface_mode != 2'h1) [*2] |-> serial_out_pin_oe_n && serial_clock_pin_oe_n)
		else $error("pins driven outside serial mode");
	chk_inhibit_abort: assert property (transfer_inhibit_bit |-> ##[0:2] !transfer_active_flag)
		else $error("inhibit did not abort");
	chk_shift_in_xfer: assert property (shift_active_flag |-> transfer_active_flag)
		else $error("shift flag without transfer flag");
	chk_irq_clear: assert property ((buf_rd || buf_wr) && buffer_service_irq |=>
		!buffer_service_irq || $changed(shift_active_flag))
		else $error("irq not cleared by buffer access");
endmodule

// file: bench/scs_peer.sv
`timescale 1ns/100ps
module scs_peer (
	input  wire logic       go,
	input  wire logic       ext,
	input  wire logic [7:0] tx_byte,
	input  wire logic       sck,
	input  wire logic       sout,
	output logic            sck_drv,
	output logic            sin,
	output logic      [7:0] rx_byte
);
	logic [7:0] txr;
	initial begin
		sck_drv = 1'b1;
		sin     = 1'b0;
		rx_byte = 8'h00;
	end
	always @(posedge go) begin
		txr = tx_byte;
		if (ext) begin
			repeat (8) begin
				#80 sck_drv = 1'b0;
				#80 sck_drv = 1'b1;
			end
		end
	end
	always @(negedge sck) begin
		sin = txr[0];
		txr = {txr[0], txr[7:1]};
	end
	always @(posedge sck) rx_byte = {sout, rx_byte[7:1]};
endmodule

// file: bench/test_clocked_serial_8bit_shifter.sv
`timescale 1ns/100ps
module test_clocked_serial_8bit_shifter;
	logic       core_clk, nrst, transfer_start_bit, transfer_inhibit_bit, buf_wr, buf_rd, go, ext;
	logic       transfer_active_flag, shift_active_flag, buffer_service_irq, serial_clock_pin_out;
	logic       serial_clock_pin_oe_n, serial_out_pin, serial_out_pin_oe_n, serial_in_pin, psck;
	logic [1:0] interface_mode, transfer_mode_field;
	logic [2:0] clk_sel;
	logic [2:0] bit_count_field = 3'h0;
	logic [7:0] buf_wdata, shared_data_buffer, ptx, prx;
	wire        serial_clock_pin_in = serial_clock_pin_oe_n ? psck : serial_clock_pin_out;
	int         error_cnt, total_checks;
	scs_shifter dut (.*);
	scs_peer peer (.go(go), .ext(ext), .tx_byte(ptx), .sck(serial_clock_pin_in), .sout(serial_out_pin),
		.sck_drv(psck), .sin(serial_in_pin), .rx_byte(prx));
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		buf_wr    = 1'b1;
		buf_wdata = d;
		tk(1);
		buf_wr = 1'b0;
	endtask
	task automatic wait_sft(input logic v);
		for (int i = 0; i < 4000 && shift_active_flag !== v; i++) tk(1);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		error_cnt++;
		conclude;
	end
	initial begin
		{nrst, transfer_start_bit, transfer_inhibit_bit, buf_wr, buf_rd, go, ext} = 7'h00;
		{interface_mode, transfer_mode_field, clk_sel, buf_wdata, ptx} = 23'h0;
		tk(8);
		chk("reset", 8'h07, {2'h0, transfer_active_flag, shift_active_flag, buffer_service_irq,
			serial_clock_pin_out, serial_clock_pin_oe_n, serial_out_pin_oe_n});
		nrst = 1'b1;
		tk(3);
		interface_mode = 2'h1;
		tk(2);
		wr(8'hA5);
		transfer_start_bit = 1'b1;
		wait_sft(1'b1);
		wait_sft(1'b0);
		chk("irq", 8'h01, {7'h0, buffer_service_irq});
		chk("sent", 8'hA5, prx);
		tk(50);
		chk("stall", 8'h05, {5'h0, transfer_active_flag, shift_active_flag, serial_clock_pin_out});
		wr(8'h3C);
		wait_sft(1'b1);
		transfer_start_bit = 1'b0;
		wait_sft(1'b0);
		tk(5);
		chk("sent2", 8'h3C, prx);
		chk("end", 8'h00, {7'h0, transfer_active_flag});
		$display("tx done");
		transfer_inhibit_bit = 1'b1;
		transfer_mode_field  = 2'h3;
		ptx                  = 8'h96;
		go                   = 1'b1;
		tk(2);
		{go, transfer_inhibit_bit, transfer_start_bit} = 3'h1;
		wait_sft(1'b1);
		wait_sft(1'b0);
		tk(2);
		chk("rx", 8'h96, shared_data_buffer);
		tk(50);
		chk("rstall", 8'h05, {5'h0, transfer_active_flag, shift_active_flag, serial_clock_pin_out});
		{transfer_start_bit, transfer_inhibit_bit} = 2'h1;
		tk(2);
		chk("abort", 8'h00, {7'h0, transfer_active_flag});
		buf_rd = 1'b1;
		tk(1);
		buf_rd = 1'b0;
		tk(1);
		chk("irqclr", 8'h00, {7'h0, buffer_service_irq});
		$display("rx done");
		{transfer_mode_field, clk_sel, ext} = 6'h2F;
		tk(2);
		transfer_inhibit_bit = 1'b0;
		wr(8'h5A);
		ptx                = 8'hC3;
		transfer_start_bit = 1'b1;
		tk(4);
		go = 1'b1;
		wait_sft(1'b1);
		transfer_start_bit = 1'b0;
		wait_sft(1'b0);
		tk(4);
		chk("dxrx", 8'hC3, shared_data_buffer);
		chk("dxtx", 8'h5A, prx);
		$display("duplex done");
		conclude;
	end
endmodule
bind scs_shifter scs_properties chk (.*);
